// ---- inc/qsmw_pkg.sv ----
/*
  Shared constants for the serial memory write and continuous-read slave:
  lane widths, lane-mode codes, command kinds and the frame state encoding.
  Assumes the importing module sizes its own address space.
*/
package qsmw_pkg;

  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;
  localparam logic [5:0] PIN_RESET = 6'h20;

  // Bits moved per serial clock edge
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;

  // Protocol lane mode (single, dual_lane_mode, quad_lane_mode)
  localparam logic [1:0] LM_SINGLE = 2'h0;
  localparam logic [1:0] LM_DUAL = 2'h1;
  localparam logic [1:0] LM_QUAD = 2'h2;

  // Decoded command kind
  localparam logic [1:0] K_NONE = 2'h0;
  localparam logic [1:0] K_WRITE = 2'h1;
  localparam logic [1:0] K_READ = 2'h2;
  localparam logic [1:0] K_WR_EN = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR = 7'h04,
    ST_MODE = 7'h08,
    ST_DATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_SKIP = 7'h40
  } qsmw_state_type;

endpackage : qsmw_pkg

// ---- rtl/qsmw_sync.sv ----
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous levels; only the second stage is read.
*/
module qsmw_sync
  import qsmw_pkg::*;
#(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : qsmw_sync

// ---- rtl/qsmw_core.sv ----
/*
  Serial memory slave: write path (single, dual, quad lanes), burst
  auto-increment with rollover, protected-range skip, write enable latch,
  and continuous-read tracking from the mode byte.
  Assumes chip select, serial clock and lanes come from an outside host in
  clock mode 0 or 3, at well under a quarter of core_clk_in; all three are
  oversampled here. Configuration ports come from logic on core_clk_in.
*/
module qsmw_core
  import qsmw_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter logic [7:0] OP_WR_EN = 8'h06,
  parameter logic [7:0] OP_WRITE = 8'h02,
  parameter logic [7:0] OP_DUAL_DW = 8'hA2,
  parameter logic [7:0] OP_QUAD_DW = 8'h32,
  parameter logic [7:0] OP_DUAL_ADW = 8'hA1,
  parameter logic [7:0] OP_QUAD_ADW = 8'hD2,
  parameter logic [7:0] OP_FREAD = 8'h0B,
  parameter logic [7:0] OP_DUAL_ORD = 8'h3B,
  parameter logic [7:0] OP_QUAD_ORD = 8'h6B,
  parameter logic [7:0] OP_DUAL_IORD = 8'hBB,
  parameter logic [7:0] OP_QUAD_IORD = 8'hEB
)
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] lane_in,
  input wire logic [1:0] lane_mode_in,
  input wire logic quad_lane_enable_in,
  input wire logic latch_clear_in,
  input wire logic protect_en_in,
  input wire logic [ADDR_W-1:0] protect_lo_in,
  input wire logic [ADDR_W-1:0] protect_hi_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_n_out,
  output logic write_enable_latch_out,
  output logic continuous_read_out,
  output logic wr_strobe_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic [7:0] rd_data_out
);

  // Shift lanes in MSB first; widest lane holds the highest bit
  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic [3:0] ln,
                                          input logic [2:0] w);
    logic [7:0] r;
    r = {sr[6:0], ln[0]};
    if (w == W2)
      r = {sr[5:0], ln[1:0]};
    else if (w == W4)
      r = {sr[3:0], ln[3:0]};
    return r;
  endfunction : shift_in

  function automatic logic [2:0] lane_width(input logic [1:0] m);
    logic [2:0] r;
    r = W1;
    if (m == LM_DUAL)
      r = W2;
    else if (m == LM_QUAD)
      r = W4;
    return r;
  endfunction : lane_width

  function automatic logic is_prot(input logic en,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    return en && (a >= lo) && (a <= hi);
  endfunction : is_prot

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    return ADDR_W'(a + 1'b1);
  endfunction : addr_inc

  // Returns {kind, address width, data or mode width}
  function automatic logic [7:0] cmd_info(input logic [7:0] op,
                                          input logic [2:0] lw,
                                          input logic qe);
    logic [7:0] r;
    r = {K_NONE, W1, W1};
    if (op == OP_WR_EN)
      r = {K_WR_EN, lw, lw};
    else if (op == OP_WRITE)
      r = {K_WRITE, lw, lw};
    else if (op == OP_FREAD)
      r = {K_READ, lw, lw};
    else if (lw == W1)
    begin
      if (op == OP_DUAL_DW)
        r = {K_WRITE, W1, W2};
      else if (op == OP_DUAL_ADW)
        r = {K_WRITE, W2, W2};
      else if (op == OP_DUAL_ORD)
        r = {K_READ, W1, W1};
      else if (op == OP_DUAL_IORD)
        r = {K_READ, W2, W2};
      else if (qe && op == OP_QUAD_DW)
        r = {K_WRITE, W1, W4};
      else if (qe && op == OP_QUAD_ADW)
        r = {K_WRITE, W4, W4};
      else if (qe && op == OP_QUAD_ORD)
        r = {K_READ, W1, W1};
      else if (qe && op == OP_QUAD_IORD)
        r = {K_READ, W4, W4};
    end
    if (lw == W4 && !qe)
      r = {K_NONE, W1, W1};
    return r;
  endfunction : cmd_info

  logic [5:0] pin_sync;
  logic sck_prev_reg;
  logic cs_prev_reg;
  qsmw_state_type state_reg, state_next;
  logic [7:0] sr_reg, sr_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [1:0] byte_cnt_reg, byte_cnt_next;
  logic [2:0] width_reg, width_next;
  logic [2:0] aw_reg, aw_next;
  logic [2:0] dw_reg, dw_next;
  logic [1:0] kind_reg, kind_next;
  logic [ADDR_W-1:0] tgt_reg, tgt_next;
  logic latch_reg, latch_next;
  logic cont_reg, cont_next;
  logic [2:0] cont_aw_reg, cont_aw_next;
  logic [2:0] cont_dw_reg, cont_dw_next;
  logic [7:0] mem [2**ADDR_W];

  qsmw_sync #(
    .WIDTH(6),
    .RESET_VAL(PIN_RESET)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({cs_n_in, sck_in, lane_in}),
    .sync_out(pin_sync)
  );

  wire cs_n_s = pin_sync[5];
  wire sck_s = pin_sync[4];
  wire [3:0] lane_s = pin_sync[3:0];
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire cs_fall = ~cs_n_s & cs_prev_reg;
  wire [7:0] shifted = shift_in(sr_reg, lane_s, width_reg);
  wire [3:0] bit_sum = bit_cnt_reg + {1'b0, width_reg};
  wire edge_ok = sck_rise & ~cs_n_s & ~cs_fall;
  wire byte_done = edge_ok & (bit_sum == BYTE_BITS);
  wire [2:0] lw = lane_width(lane_mode_in);
  wire [7:0] info = cmd_info(shifted, lw, quad_lane_enable_in);
  wire [ADDR_W+7:0] addr_shift = {tgt_reg, shifted};
  wire prot = is_prot(protect_en_in, tgt_reg, protect_lo_in, protect_hi_in);
  wire in_data = (state_reg == ST_DATA);
  wire mem_we = byte_done & in_data & latch_reg & ~prot;

  always_comb
  begin
    state_next = state_reg;
    sr_next = sr_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    width_next = width_reg;
    aw_next = aw_reg;
    dw_next = dw_reg;
    kind_next = kind_reg;
    tgt_next = tgt_reg;
    latch_next = latch_reg;
    cont_next = cont_reg;
    cont_aw_next = cont_aw_reg;
    cont_dw_next = cont_dw_reg;
    if (latch_clear_in)
      latch_next = 1'b0;
    if (cs_n_s)
    begin
      // Select high ends the frame; a partial byte is dropped
      state_next = ST_IDLE;
      bit_cnt_next = '0;
      byte_cnt_next = '0;
    end
    else if (cs_fall)
    begin
      bit_cnt_next = '0;
      byte_cnt_next = '0;
      if (cont_reg)
      begin
        // Frame starts straight at the address
        state_next = ST_ADDR;
        kind_next = K_READ;
        width_next = cont_aw_reg;
        aw_next = cont_aw_reg;
        dw_next = cont_dw_reg;
      end
      else
      begin
        state_next = ST_OPCODE;
        width_next = lw;
      end
    end
    else if (sck_rise)
    begin
      sr_next = shifted;
      bit_cnt_next = bit_sum;
      if (bit_sum == BYTE_BITS)
      begin
        bit_cnt_next = '0;
        case (state_reg)
          ST_OPCODE:
          begin
            kind_next = info[7:6];
            aw_next = info[5:3];
            dw_next = info[2:0];
            width_next = info[5:3];
            state_next = ST_SKIP;
            if (info[7:6] == K_WR_EN)
              latch_next = 1'b1;
            else if (info[7:6] == K_READ)
              state_next = ST_ADDR;
            else if (info[7:6] == K_WRITE && latch_reg)
              state_next = ST_ADDR;
          end
          ST_ADDR:
          begin
            // High bits of the first byte fall off the top
            tgt_next = addr_shift[ADDR_W-1:0];
            byte_cnt_next = byte_cnt_reg + 2'h1;
            if (byte_cnt_reg == ADDR_LAST_BYTE)
            begin
              width_next = dw_reg;
              state_next = (kind_reg == K_WRITE) ? ST_DATA : ST_MODE;
            end
          end
          ST_MODE:
          begin
            // Low nibble may be undriven, so it is never looked at
            cont_next = (shifted[7:4] == CONT_NIBBLE);
            cont_aw_next = aw_reg;
            cont_dw_next = dw_reg;
            state_next = ST_RDATA;
          end
          ST_DATA:
            tgt_next = addr_inc(tgt_reg);
          default:
            state_next = state_reg;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      sr_reg <= '0;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      width_reg <= W1;
      aw_reg <= W1;
      dw_reg <= W1;
      kind_reg <= K_NONE;
      tgt_reg <= '0;
      latch_reg <= 1'b0;
      cont_reg <= 1'b0;
      cont_aw_reg <= W1;
      cont_dw_reg <= W1;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_n_s;
      state_reg <= state_next;
      sr_reg <= sr_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      width_reg <= width_next;
      aw_reg <= aw_next;
      dw_reg <= dw_next;
      kind_reg <= kind_next;
      tgt_reg <= tgt_next;
      latch_reg <= latch_next;
      cont_reg <= cont_next;
      cont_aw_reg <= cont_aw_next;
      cont_dw_reg <= cont_dw_next;
    end
  end

  // Array has no reset; contents are whatever was last stored
  always_ff @(posedge core_clk_in)
  begin
    if (mem_we)
      mem[tgt_reg] <= shifted;
    rd_data_out <= mem[rd_addr_in];
  end

  // Read data is not driven by this block, so the lanes stay released
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      lane_out <= '0;
      lane_oe_n_out <= 4'hF;
      wr_strobe_out <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= '0;
    end
    else
    begin
      lane_out <= '0;
      lane_oe_n_out <= 4'hF;
      wr_strobe_out <= mem_we;
      if (mem_we)
      begin
        wr_addr_out <= tgt_reg;
        wr_data_out <= shifted;
      end
    end
  end

  assign write_enable_latch_out = latch_reg;
  assign continuous_read_out = cont_reg;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  store_gate_a: assert property (wr_strobe_out |-> $past(latch_reg))
    else $error("store without enable latch");
  latch_keep_a: assert property ($fell(latch_reg) |->
    $past(latch_clear_in))
    else $error("enable latch dropped without clear");
  addr_step_a: assert property (byte_done && in_data |=>
    tgt_reg == addr_inc($past(tgt_reg)))
    else $error("burst address did not advance by one");
  addr_wrap_a: assert property (byte_done && in_data && tgt_reg == '1
    |=> tgt_reg == '0)
    else $error("burst address did not wrap");
  prot_skip_a: assert property (wr_strobe_out |->
    !$past(prot) && wr_addr_out == $past(tgt_reg))
    else $error("store into protected range");
  cont_set_a: assert property (byte_done && state_reg == ST_MODE &&
    shifted[7:4] == CONT_NIBBLE |=> cont_reg)
    else $error("continuous read not kept");
  cont_addr_a: assert property (cs_fall && cont_reg |=>
    state_reg == ST_ADDR && kind_reg == K_READ)
    else $error("continuous frame did not start at address");
  cont_clr_a: assert property (byte_done && state_reg == ST_MODE &&
    shifted[7:4] != CONT_NIBBLE |=> !cont_reg)
    else $error("continuous read not left");
  quad_gate_a: assert property ($rose(state_reg == ST_ADDR) &&
    $past(state_reg) == ST_OPCODE && (width_reg == W4 || dw_reg == W4)
    |-> $past(quad_lane_enable_in))
    else $error("quad command without quad enable");
  partial_drop_a: assert property ($rose(cs_n_s) |=>
    state_reg == ST_IDLE && bit_cnt_reg == '0 ##1 !wr_strobe_out)
    else $error("partial byte not dropped");

  burst_wrap_c: cover property (byte_done && in_data && tgt_reg == '1);
  cont_enter_c: cover property ($rose(cont_reg));
  quad_write_c: cover property (mem_we && width_reg == W4);
  prot_skip_c: cover property (byte_done && in_data && prot);

endmodule : qsmw_core

// ---- tb/qsmw_host.sv ----
/*
  Host controller model: chip select, mode 0 serial clock, four lanes.
  Assumes clk_in is the 4 ns core clock; sck period is 12 of its cycles.
*/
module qsmw_host
(
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] lane_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    lane_out = 4'hA;
  end

  task automatic half();
    repeat (6) @(posedge clk_in);
  endtask : half

  task automatic start();
    half();
    cs_n_out <= 1'b0;
    half();
  endtask : start

  // Released lanes flip so a stale level never looks valid
  task automatic stop();
    half();
    cs_n_out <= 1'b1;
    lane_out <= ~lane_out;
    half();
  endtask : stop

  // n beats of w bits, bit 7 first and on the top lane
  task automatic send(input logic [7:0] b, input int w, input int n);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < n; i++)
    begin
      lane_out <= 4'(s >> (8 - w));
      s = s << w;
      half();
      sck_out <= 1'b1;
      half();
      sck_out <= 1'b0;
    end
  endtask : send
endmodule : qsmw_host

// ---- tb/tb_qsmw_core.sv ----
/*
  Self-checking bench for the serial memory slave core.
  Assumes the core's default opcodes and a 17-bit address space.
*/
module tb_qsmw_core
  import qsmw_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck;
  logic [3:0] lane, lane_o, oe_n;
  logic [1:0] lmode = LM_SINGLE;
  logic qe = 1'b1;
  logic wclr = 1'b0;
  logic pen = 1'b0;
  logic [16:0] plo = '0;
  logic [16:0] phi = '0;
  logic [16:0] rda = '0;
  logic latch, cont, stb;
  logic [16:0] wa;
  logic [7:0] wd, rdd;
  logic [16:0] sa[$];
  logic [7:0] sd[$];
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2 core_clk = ~core_clk;

  qsmw_host host
  (
    .clk_in(core_clk),
    .cs_n_out(cs_n),
    .sck_out(sck),
    .lane_out(lane)
  );

  qsmw_core dut
  (
    .core_clk_in(core_clk),
    .sys_rst_in(rst),
    .cs_n_in(cs_n),
    .sck_in(sck),
    .lane_in(lane),
    .lane_mode_in(lmode),
    .quad_lane_enable_in(qe),
    .latch_clear_in(wclr),
    .protect_en_in(pen),
    .protect_lo_in(plo),
    .protect_hi_in(phi),
    .rd_addr_in(rda),
    .lane_out(lane_o),
    .lane_oe_n_out(oe_n),
    .write_enable_latch_out(latch),
    .continuous_read_out(cont),
    .wr_strobe_out(stb),
    .wr_addr_out(wa),
    .wr_data_out(wd),
    .rd_data_out(rdd)
  );

  always @(posedge core_clk)
  begin
    if (stb === 1'b1)
    begin
      sa.push_back(wa);
      sd.push_back(wd);
    end
  end

  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Generous ceiling: the whole sequence needs about 10000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr_enable(input int w);
    host.start();
    host.send(8'h06, w, 8 / w);
    host.stop();
  endtask : wr_enable

  // ow 0 leaves the opcode out; first address byte has junk above A16
  task automatic xfer(input logic [7:0] op, input int ow, aw, dw,
                      input logic [16:0] a, input logic [7:0] d[$],
                      input int tail);
    sa.delete();
    sd.delete();
    host.start();
    if (ow > 0)
      host.send(op, ow, 8 / ow);
    host.send({7'h7F, a[16]}, aw, 8 / aw);
    host.send(a[15:8], aw, 8 / aw);
    host.send(a[7:0], aw, 8 / aw);
    foreach (d[i])
      host.send(d[i], dw, 8 / dw);
    if (tail > 0)
      host.send(8'hFF, dw, tail);
    host.stop();
  endtask : xfer

  task automatic store(input int k, input logic [16:0] a,
                       input logic [7:0] d);
    check("store_addr", sa[k], a);
    check("store_data", sd[k], d);
  endtask : store

  // Latch set, then cleared from outside, so the refusal is real
  task automatic t_refuse();
    wr_enable(1);
    check("latch", latch, 1'b1);
    wclr <= 1'b1;
    cyc(2);
    wclr <= 1'b0;
    cyc(1);
    check("latch", latch, 1'b0);
    xfer(8'h02, 1, 1, 1, 17'h00010, '{8'h5A}, 0);
    check("stores", sa.size(), 0);
    check("latch", latch, 1'b0);
  endtask : t_refuse

  task automatic t_single();
    wr_enable(1);
    check("latch", latch, 1'b1);
    xfer(8'h02, 1, 1, 1, 17'h00010, '{8'h5A}, 0);
    check("stores", sa.size(), 1);
    store(0, 17'h00010, 8'h5A);
    check("latch", latch, 1'b1);
    rda <= 17'h00010;
    cyc(3);
    check("array", rdd, 8'h5A);
  endtask : t_single

  // Protected top byte skipped, wrap to zero, partial tail dropped
  task automatic t_burst();
    pen <= 1'b1;
    plo <= 17'h1FFFF;
    phi <= 17'h1FFFF;
    xfer(8'h02, 1, 1, 1, 17'h1FFFE, '{8'hA1, 8'hB2, 8'hC3}, 4);
    check("stores", sa.size(), 2);
    store(0, 17'h1FFFE, 8'hA1);
    store(1, 17'h00000, 8'hC3);
    pen <= 1'b0;
  endtask : t_burst

  task automatic t_lanes();
    logic [7:0] ops[7] = '{8'h02, 8'h02, 8'h02, 8'hA2, 8'h32, 8'hA1,
                           8'hD2};
    logic [11:0] ws[7] = '{12'h111, 12'h222, 12'h444, 12'h112, 12'h114,
                           12'h122, 12'h144};
    logic [16:0] a;
    for (int i = 0; i < 7; i++)
    begin
      lmode <= (i < 3) ? 2'(i) : LM_SINGLE;
      a = 17'h10200 + 17'(i);
      xfer(ops[i], ws[i][11:8], ws[i][7:4], ws[i][3:0], a,
           '{8'h96 + 8'(i)}, 0);
      store(0, a, 8'h96 + 8'(i));
    end
    lmode <= LM_SINGLE;
  endtask : t_lanes

  task automatic t_quadoff();
    qe <= 1'b0;
    xfer(8'h32, 1, 1, 4, 17'h00300, '{8'h55}, 0);
    check("stores", sa.size(), 0);
    lmode <= LM_QUAD;
    xfer(8'h02, 4, 4, 4, 17'h00301, '{8'h55}, 0);
    check("stores", sa.size(), 0);
    lmode <= LM_SINGLE;
    qe <= 1'b1;
  endtask : t_quadoff

  // Enter, stay and leave continuous mode for every supported read
  task automatic t_cont();
    logic [7:0] ops[5] = '{8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
    int aw[5] = '{1, 1, 1, 2, 4};
    for (int i = 0; i < 5; i++)
    begin
      xfer(ops[i], 1, aw[i], aw[i], 17'h00400, '{8'hA0 + 8'(i)}, 0);
      check("cont", cont, 1'b1);
      xfer(8'h00, 0, aw[i], aw[i], 17'h00410, '{8'hAF}, 0);
      check("cont", cont, 1'b1);
      xfer(8'h00, 0, aw[i], aw[i], 17'h00420, '{8'h5A}, 0);
      check("cont", cont, 1'b0);
      check("stores", sa.size(), 0);
    end
  endtask : t_cont

  initial
  begin
    cyc(5);
    rst <= 1'b0;
    cyc(3);
    check("idle_oe", oe_n, 4'hF);
    check("idle_lane", lane_o, 4'h0);
    t_refuse();
    t_single();
    t_burst();
    t_cont();
    t_lanes();
    t_quadoff();
    summarize();
  end
endmodule : tb_qsmw_core
